// ===== rtl/mpr_top.sv
// Monitor pulse rate output: settings registers, rate computation and the
// phase accumulator that drives the monitor pulse terminal.
// Assumes monitored values come from logic on the same clock, in hundredths.
`timescale 1ns/100ps
`default_nettype none
`include "mpr_consts.svh"

module mpr_top
   import mpr_pkg::*;
#(
   parameter logic [15:0] RATED_CURR = 16'h01F4
)
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [4:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] freq_mon_i,
   input wire logic [15:0] curr_mon_i,
   output logic [31:0] rdata_o,
   output logic monitor_pulse_terminal_o
);

   localparam int PULSE_CYC = `MPR_PULSE_CYC;

   logic [15:0] freq_fs_r;
   logic [15:0] curr_fs_r;
   logic [7:0] sel_r;
   logic [15:0] trim_r;
   logic [7:0] ext_disp_r;
   logic [7:0] wp_sel_r;
   logic [15:0] inc_r;
   logic sat_r;
   logic [31:0] acc_r;
   logic [13:0] pcnt_r;
   mpr_calc_state_t state_r;
   logic div_start;
   logic div_busy;
   logic div_done;
   logic [`MPR_NUM_W-1:0] div_num;
   logic [15:0] div_den;
   logic [`MPR_NUM_W-1:0] div_quot;
   logic [32:0] acc_sum;
   logic [23:0] nom_scaled;
   logic [15:0] mon_val;
   logic rated_loaded_r;
   logic rated_done_r;

   // Write to a given register in this cycle.
   function automatic logic wr_hit(input logic [4:0] ofs);
      return wr_i && (addr_i == ofs);
   endfunction

   // Clamp a raw quotient to the largest legal increment.
   function automatic logic [15:0] clamp_inc(input logic [`MPR_NUM_W-1:0] q);
      if (q > {24'h00_0000, `MPR_INC_MAX})
         return `MPR_INC_MAX;
      return q[15:0];
   endfunction

   // full-scale range check
   // Protection and drive state are not consulted: both are live settings.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         freq_fs_r <= `MPR_FREQ_FS_RST;
         curr_fs_r <= 16'h0000;
      end else begin
         // Rated current is loaded once; a write in that cycle wins.
         if (rated_loaded_r && !rated_done_r)
            curr_fs_r <= RATED_CURR;
         if (wr_hit(`MPR_OFS_FREQ_FS) && wdata_i <= 32'(`MPR_FREQ_FS_MAX))
            freq_fs_r <= wdata_i[15:0];
         if (wr_hit(`MPR_OFS_CURR_FS) && wdata_i <= 32'(`MPR_CURR_FS_MAX))
            curr_fs_r <= wdata_i[15:0];
      end
   end

   // Rated current cannot enter the async reset, so load it once after.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i)
         rated_loaded_r <= 1'b0;
      else
         rated_loaded_r <= 1'b1;
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         trim_r <= `MPR_TRIM_RST;
         sel_r <= `MPR_SEL_RST;
         ext_disp_r <= 8'h00;
         wp_sel_r <= 8'h00;
      end else begin
         if (wr_hit(`MPR_OFS_TRIM) && ext_disp_r == 8'h00)
            trim_r <= wdata_i[15:0];
         if (wr_hit(`MPR_OFS_MON_SEL))
            sel_r <= wdata_i[7:0];
         if (wr_hit(`MPR_OFS_EXT_DISP))
            ext_disp_r <= wdata_i[7:0];
         if (wr_hit(`MPR_OFS_WP_SEL))
            wp_sel_r <= wdata_i[7:0];
      end
   end

   // Read data stand for one cycle after the read strobe; unmapped reads 0.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         unique case (addr_i)
            `MPR_OFS_FREQ_FS: rdata_o <= {16'h0000, freq_fs_r};
            `MPR_OFS_CURR_FS: rdata_o <= {16'h0000, curr_fs_r};
            `MPR_OFS_MON_SEL: rdata_o <= {24'h00_0000, sel_r};
            `MPR_OFS_TRIM: rdata_o <= {16'h0000, trim_r};
            `MPR_OFS_EXT_DISP: rdata_o <= {24'h00_0000, ext_disp_r};
            `MPR_OFS_WP_SEL: rdata_o <= {24'h00_0000, wp_sel_r};
            `MPR_OFS_STATUS: rdata_o <= {15'h0000, sat_r, inc_r};
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // increment scaling
   // The trim multiplies the nominal increment before the ratio is taken.
   assign mon_val = (sel_r == `MPR_SEL_CURR) ? curr_mon_i : freq_mon_i;
   assign nom_scaled = 24'((32'(`MPR_INC_NOM) * 32'(trim_r))
                           >> `MPR_TRIM_FRAC);
   assign div_num = 40'(mon_val) * 40'(nom_scaled);
   assign div_den = (sel_r == `MPR_SEL_CURR) ? curr_fs_r : freq_fs_r;
   assign div_start = (state_r == MPR_CALC_IDLE) && rated_done_r &&
                      (sel_r != `MPR_SEL_REF) && (div_den != 16'h0000) &&
                      !div_busy;

   mpr_div i_mpr_div (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .start_i(div_start),
      .num_i(div_num),
      .den_i(div_den),
      .busy_o(div_busy),
      .done_o(div_done),
      .quot_o(div_quot)
   );

   // Increment recomputed continuously, about every 42 cycles.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= MPR_CALC_IDLE;
         inc_r <= 16'h0000;
         sat_r <= 1'b0;
      end else begin
         unique case (state_r)
            MPR_CALC_IDLE: begin
               if (sel_r == `MPR_SEL_REF) begin
                  inc_r <= `MPR_INC_NOM;
                  sat_r <= 1'b0;
               end else if (div_start) begin
                  state_r <= MPR_CALC_WAIT;
               end else if (rated_done_r && div_den == 16'h0000) begin
                  // A zero full scale means any value is off the scale.
                  inc_r <= `MPR_INC_MAX;
                  sat_r <= 1'b1;
               end
            end
            MPR_CALC_WAIT: begin
               if (div_done) begin
                  inc_r <= clamp_inc(div_quot);
                  sat_r <= (clamp_inc(div_quot) != div_quot[15:0]) ||
                           (div_quot[`MPR_NUM_W-1:16] != 24'h00_0000);
                  state_r <= MPR_CALC_IDLE;
               end
            end
         endcase
      end
   end

   // Rated current becomes the current full scale once reset is released.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i)
         rated_done_r <= 1'b0;
      else
         rated_done_r <= rated_loaded_r;
   end

   assign acc_sum = {1'b0, acc_r} + {17'h0_0000, inc_r};
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_r <= 32'h0000_0000;
         pcnt_r <= 14'h0000;
         monitor_pulse_terminal_o <= 1'b0;
      end else begin
         acc_r <= acc_sum[31:0];
         if (acc_sum[32]) begin
            pcnt_r <= 14'(PULSE_CYC - 1);
            monitor_pulse_terminal_o <= 1'b1;
         end else if (pcnt_r != 14'h0000) begin
            pcnt_r <= pcnt_r - 14'h0001;
         end else begin
            monitor_pulse_terminal_o <= 1'b0;
         end
      end
   end

   // Assertions.
   property p_inc_cap;
      @(posedge clock_i) disable iff (!nrst_i)
      inc_r <= `MPR_INC_MAX;
   endproperty
   a_inc_cap: assert property (p_inc_cap)
      else $error("increment above maximum rate");

   property p_ref_rate;
      @(posedge clock_i) disable iff (!nrst_i)
      (state_r == MPR_CALC_IDLE && sel_r == `MPR_SEL_REF)
         |=> inc_r == `MPR_INC_NOM;
   endproperty
   a_ref_rate: assert property (p_ref_rate)
      else $error("reference mode increment wrong");

   property p_clamp;
      @(posedge clock_i) disable iff (!nrst_i)
      (state_r == MPR_CALC_WAIT && div_done &&
       div_quot > 40'(`MPR_INC_MAX)) |=> (inc_r == `MPR_INC_MAX) && sat_r;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("oversize rate not clamped");

   property p_linear;
      @(posedge clock_i) disable iff (!nrst_i)
      (state_r == MPR_CALC_WAIT && div_done &&
       div_quot <= 40'(`MPR_INC_MAX)) |=> inc_r == $past(div_quot[15:0]);
   endproperty
   a_linear: assert property (p_linear)
      else $error("increment not taken from quotient");

   property p_fs_write;
      @(posedge clock_i) disable iff (!nrst_i)
      (wr_i && addr_i == `MPR_OFS_FREQ_FS &&
       wdata_i <= 32'(`MPR_FREQ_FS_MAX))
         |=> freq_fs_r == $past(wdata_i[15:0]);
   endproperty
   a_fs_write: assert property (p_fs_write)
      else $error("frequency full scale write lost");

   property p_curr_range;
      @(posedge clock_i) disable iff (!nrst_i)
      (wr_i && addr_i == `MPR_OFS_CURR_FS &&
       wdata_i > 32'(`MPR_CURR_FS_MAX))
         |=> $stable(curr_fs_r);
   endproperty
   a_curr_range: assert property (p_curr_range)
      else $error("out of range current full scale taken");

   property p_trim_lock;
      @(posedge clock_i) disable iff (!nrst_i)
      (wr_i && addr_i == `MPR_OFS_TRIM && ext_disp_r != 8'h00)
         |=> $stable(trim_r);
   endproperty
   a_trim_lock: assert property (p_trim_lock)
      else $error("trim written while extended display set");

   property p_trim_write;
      @(posedge clock_i) disable iff (!nrst_i)
      (wr_i && addr_i == `MPR_OFS_TRIM && ext_disp_r == 8'h00)
         |=> trim_r == $past(wdata_i[15:0]);
   endproperty
   a_trim_write: assert property (p_trim_write)
      else $error("trim write lost");

   property p_pulse_start;
      @(posedge clock_i) disable iff (!nrst_i)
      acc_sum[32] |=> monitor_pulse_terminal_o &&
                      pcnt_r == 14'(PULSE_CYC - 1);
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("overflow did not start a pulse");

   c_ref: cover property (@(posedge clock_i) disable iff (!nrst_i)
      sel_r == `MPR_SEL_REF && $rose(monitor_pulse_terminal_o));
   c_sat: cover property (@(posedge clock_i) disable iff (!nrst_i)
      $rose(sat_r));
   c_curr: cover property (@(posedge clock_i) disable iff (!nrst_i)
      sel_r == `MPR_SEL_CURR && div_done);

endmodule
`default_nettype wire

// ===== rtl/mpr_consts.svh
// Constants for the monitor pulse rate output block: register offsets,
// reset values, field codes and timing counts.
// Assumes a 250 MHz core clock and byte addresses on a 5-bit register port.
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH

// Register byte offsets.
`define MPR_OFS_FREQ_FS 5'h00
`define MPR_OFS_CURR_FS 5'h04
`define MPR_OFS_MON_SEL 5'h08
`define MPR_OFS_TRIM 5'h0C
`define MPR_OFS_EXT_DISP 5'h10
`define MPR_OFS_WP_SEL 5'h14
`define MPR_OFS_STATUS 5'h18

// Settings are in hundredths of a hertz or of an ampere.
`define MPR_FREQ_FS_MAX 16'h9C40
`define MPR_FREQ_FS_RST 16'h1770
`define MPR_CURR_FS_MAX 16'hC350

// Monitor selection codes; trim is unsigned 8.8 fixed point.
`define MPR_SEL_FREQ 8'h01
`define MPR_SEL_CURR 8'h02
`define MPR_SEL_REF 8'h15
`define MPR_SEL_RST 8'h01
`define MPR_TRIM_RST 16'h0100
`define MPR_TRIM_FRAC 8

// Rates and accumulator increments for a 32-bit phase accumulator.
`define MPR_CLK_HZ 64'd250000000
`define MPR_NOM_PPS 64'd1440
`define MPR_MAX_PPS 64'd2400
`define MPR_INC_NOM (16'((`MPR_NOM_PPS << 32) / `MPR_CLK_HZ))
`define MPR_INC_MAX (16'((`MPR_MAX_PPS << 32) / `MPR_CLK_HZ))

// Output pulse width, rounded up to whole clock cycles.
`define MPR_CLK_PERIOD_NS 4
`define MPR_PULSE_NS 10000
`define MPR_PULSE_CYC ((`MPR_PULSE_NS + `MPR_CLK_PERIOD_NS - 1) / `MPR_CLK_PERIOD_NS)

// Divider geometry.
`define MPR_NUM_W 40
`define MPR_DEN_W 16

`endif

// ===== rtl/mpr_pkg.sv
// Types for the monitor pulse rate output block.
// Assumes mpr_consts.svh supplies all numeric constants.
package mpr_pkg;

   // Increment computation sequencer.
   typedef enum logic [0:0] {
      MPR_CALC_IDLE,
      MPR_CALC_WAIT
   } mpr_calc_state_t;

endpackage

// ===== rtl/mpr_div.sv
// Sequential restoring divider used to scale the monitor value.
// Assumes start is a one-cycle pulse issued only while the unit is idle.
`timescale 1ns/100ps
`default_nettype none
`include "mpr_consts.svh"

module mpr_div
   import mpr_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire logic [`MPR_NUM_W-1:0] num_i,
   input wire logic [`MPR_DEN_W-1:0] den_i,
   output logic busy_o,
   output logic done_o,
   output logic [`MPR_NUM_W-1:0] quot_o
);

   logic [`MPR_DEN_W-1:0] rem_r;
   logic [`MPR_DEN_W-1:0] den_r;
   logic [5:0] cnt_r;
   logic [`MPR_DEN_W:0] trial;

   // Partial remainder with the next numerator bit shifted in.
   assign trial = {rem_r, quot_o[`MPR_NUM_W-1]};

   // One quotient bit per cycle; the result is held until the next start.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rem_r <= 16'h0000;
         den_r <= 16'h0000;
         cnt_r <= 6'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         quot_o <= 40'h00_0000_0000;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            rem_r <= 16'h0000;
            den_r <= den_i;
            quot_o <= num_i;
            cnt_r <= 6'(`MPR_NUM_W);
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (trial >= {1'b0, den_r}) begin
               rem_r <= 16'(trial - {1'b0, den_r});
               quot_o <= {quot_o[`MPR_NUM_W-2:0], 1'b1};
            end else begin
               rem_r <= trial[`MPR_DEN_W-1:0];
               quot_o <= {quot_o[`MPR_NUM_W-2:0], 1'b0};
            end
            cnt_r <= cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== sim/mpr_meter_model.sv
// Pulse counter model standing on the monitor pulse terminal.
// Assumes it shares the core clock; it only listens and never drives.
`timescale 1ns/100ps
`default_nettype none

module mpr_meter_model
   import mpr_pkg::*;
(
   input wire logic clock_i,
   input wire logic pulse_i,
   output logic [31:0] count_o,
   output logic [31:0] width_o
);
   logic [31:0] run_r;

   // The counter starts empty, as a meter does when first connected.
   // A counter sees only edges, so the high time is rebuilt by counting.
   initial begin
      count_o = 32'h0;
      width_o = 32'h0;
      run_r = 32'h0;
      forever begin
         @(posedge clock_i);
         if (pulse_i === 1'b1) begin
            run_r <= run_r + 32'h1;
         end else if (run_r != 32'h0) begin
            width_o <= run_r;
            count_o <= count_o + 32'h1;
            run_r <= 32'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/test_mpr_top.sv
// Self-checking bench for the monitor pulse rate block.
// Assumes a 250 MHz clock and the register map of the constants header.
`timescale 1ns/100ps
`default_nettype none
`include "mpr_consts.svh"

module test_mpr_top
   import mpr_pkg::*;
;
   localparam logic [15:0] RATED = 16'h03E8;
   logic clock = 1'b0;
   logic nrst_n = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] freq_mon = 16'h0;
   logic [15:0] curr_mon = 16'h0;
   logic [31:0] rdata;
   logic pulse;
   logic [31:0] m_count;
   logic [31:0] m_width;
   logic [31:0] seed = 32'h000156BB;
   logic [7:0] sels [4] = '{8'h01, 8'h02, 8'h15, 8'h07};
   int num_errors = 0;
   int cmp_count = 0;

   // Half period of 2 ns gives the 4 ns core clock.
   always #2 clock = ~clock;

   mpr_top #(.RATED_CURR(RATED)) i_mpr_top (.clock_i(clock),
      .nrst_i(nrst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .freq_mon_i(freq_mon), .curr_mon_i(curr_mon),
      .rdata_o(rdata), .monitor_pulse_terminal_o(pulse));
   mpr_meter_model i_mpr_meter_model (.clock_i(clock), .pulse_i(pulse),
      .count_o(m_count), .width_o(m_width));

   // Xorshift keeps the random run repeatable from its fixed seed.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected status word: bit 16 saturated, low half the increment.
   // 0x60A3 is the 1440/s step and 0xA10F the 2400/s step at 250 MHz.
   function automatic logic [31:0] exp_status(logic [7:0] sel,
      logic [15:0] fm, logic [15:0] cm, logic [15:0] ffs,
      logic [15:0] cfs, logic [15:0] trim);
      logic [63:0] k;
      logic [63:0] q;
      logic [15:0] fs;
      k = (64'h60A3 * trim) >> 8;
      fs = (sel == 8'h02) ? cfs : ffs;
      if (sel == 8'h15) return 32'h000060A3;
      if (fs == 16'h0) return 32'h0001A10F;
      q = ((sel == 8'h02) ? cm : fm) * k / fs;
      if (q > 64'hA10F) return 32'h0001A10F;
      return {16'h0, q[15:0]};
   endfunction

   task automatic chk_reg(string n, logic [31:0] e, logic [31:0] a);
      cmp_count++;
      if (a !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, a);
      end
   endtask

   task automatic chk_time(string n, logic [31:0] e, logic [31:0] a);
      cmp_count++;
      if (a !== e) begin
         num_errors++;
         $display("Error %s expected %0d seen %0d", n, e, a);
      end
   endtask

   task automatic reg_wr(logic [4:0] a, logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_chk(string n, logic [4:0] a, logic [31:0] e);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      chk_reg(n, e, rdata);
   endtask

   // Load full scales, selection and trim, let the increment settle, then check status.
   task automatic setup(logic [7:0] sel, logic [15:0] fm, logic [15:0] cm,
      logic [15:0] ffs, logic [15:0] cfs, logic [15:0] trim);
      reg_wr(`MPR_OFS_FREQ_FS, {16'h0, ffs});
      reg_wr(`MPR_OFS_CURR_FS, {16'h0, cfs});
      reg_wr(`MPR_OFS_MON_SEL, {24'h0, sel});
      reg_wr(`MPR_OFS_TRIM, {16'h0, trim});
      freq_mon <= fm;
      curr_mon <= cm;
      repeat (150) @(posedge clock);
      rd_chk("status", `MPR_OFS_STATUS, exp_status(sel, fm, cm, ffs, cfs,
         trim));
   endtask

   task automatic close_out();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // A hung wait must not stall the run beyond the pulse scenario.
   initial begin
      repeat (130000) @(posedge clock);
      num_errors++;
      close_out();
   end

   initial begin
      repeat (2) @(posedge clock);
      nrst_n <= 1'b1;
      rd_chk("freq_fs", `MPR_OFS_FREQ_FS, 32'h1770);
      rd_chk("curr_fs", `MPR_OFS_CURR_FS, {16'h0, RATED});
      rd_chk("mon_sel", `MPR_OFS_MON_SEL, 32'h1);
      rd_chk("trim", `MPR_OFS_TRIM, 32'h100);
      rd_chk("wp_sel", `MPR_OFS_WP_SEL, 32'h0);
      rd_chk("ext_disp", `MPR_OFS_EXT_DISP, 32'h0);
      rd_chk("unmapped", 5'h1C, 32'h0);
      // Default scaling: 60 Hz is nominal, 100 Hz reaches the maximum rate without saturating.
      setup(8'h01, 16'h1770, 16'h0, 16'h1770, RATED, 16'h100);
      setup(8'h01, 16'h2710, 16'h0, 16'h1770, RATED, 16'h100);
      // Out of range full-scale writes are dropped; bounds are kept.
      reg_wr(`MPR_OFS_FREQ_FS, 32'h9C41);
      rd_chk("freq_fs", `MPR_OFS_FREQ_FS, 32'h1770);
      reg_wr(`MPR_OFS_FREQ_FS, 32'h9C40);
      rd_chk("freq_fs", `MPR_OFS_FREQ_FS, 32'h9C40);
      reg_wr(`MPR_OFS_CURR_FS, 32'hC351);
      rd_chk("curr_fs", `MPR_OFS_CURR_FS, {16'h0, RATED});
      reg_wr(`MPR_OFS_CURR_FS, 32'hC350);
      rd_chk("curr_fs", `MPR_OFS_CURR_FS, 32'hC350);
      reg_wr(`MPR_OFS_WP_SEL, 32'h2);
      reg_wr(`MPR_OFS_FREQ_FS, 32'h2EE0);
      rd_chk("freq_fs", `MPR_OFS_FREQ_FS, 32'h2EE0);
      // Trim is gated by the extended display select, live inputs moving.
      freq_mon <= 16'h1234;
      reg_wr(`MPR_OFS_EXT_DISP, 32'h1);
      reg_wr(`MPR_OFS_TRIM, 32'h200);
      rd_chk("trim", `MPR_OFS_TRIM, 32'h100);
      reg_wr(`MPR_OFS_EXT_DISP, 32'h0);
      reg_wr(`MPR_OFS_TRIM, 32'h200);
      rd_chk("trim", `MPR_OFS_TRIM, 32'h200);
      setup(8'h15, 16'hFFFF, 16'hFFFF, 16'h2EE0, 16'hC350, 16'h200);
      setup(8'h02, 16'h0, 16'h1388, 16'h1770, 16'h1388, 16'h100);
      setup(8'h01, 16'h2EE0, 16'h0, 16'h2EE0, 16'h1388, 16'h100);
      // Random mix of monitors, scales and trims, saturation included.
      for (int i = 0; i < 16; i++) begin
         setup(sels[rnd() % 4], rnd(), rnd(), rnd() % 40001, rnd() % 50001,
            rnd() % 32'h300);
      end
      // Fastest rate gives the earliest pulse for the meter to time.
      setup(8'h01, 16'hFFFF, 16'h0, 16'h0001, 16'hC350, 16'h100);
      for (int i = 0; i < 110000 && m_count == 32'h0; i++) begin
         @(posedge clock);
      end
      chk_time("pulse width", 32'd2500, m_width);
      close_out();
   end
endmodule
`default_nettype wire
